// File: verilog/spv_device.sv
// Supervisor: masked interrupt unit and power mode sequencer.
`timescale 1ns/1ns
// Behaviour
// - Four mask bits: bus, heat, overheat/tracker, supply.
// - Enabled fault pulls interrupt low; masked never.
// - D2 reads one for overheat, zero tracker.
// - Over-current wake with stop selected pulses interrupt, status stays zero.
// - Status mirrors latched flags; source read clears.
// - Fault flags stay latched until register read.
// - Power-up enters normal-request, main regulator on.
// - No timing write in 350 ms resets.
// - First timing write enters normal, tracker on.
// - Missed refresh resets, back to normal-request.
// - Undervoltage with stop selected enters reset mode.
// - Overload gone, restart in normal-request mode.
// - Undervoltage with sleep, no battery loss: 100 ms reset, sleep.
// - Sleep wake holds reset through start-up time.
// - Interrupt bit order D3..D0, cleared on reset.
module spv_device #(
   parameter int TICK_CYC = spv_pkg::TICK_CYCLES
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   spv_link_if.dev            link,
   input  wire logic          bus_fault_flag,
   input  wire logic          regulator_heat_warning,
   input  wire logic          high_side_overheat,
   input  wire logic          tracker_undervoltage,
   input  wire logic          battery_supply_low,
   input  wire logic          main_regulator_output_low,
   input  wire logic          overcurrent_wake,
   input  wire logic          wake_event,
   input  wire logic          battery_loss_flag,
   output logic               main_regulator_output_en,
   output logic               tracker_en,
   output logic               can_txrx_en,
   output spv_pkg::spv_mode_type mode
);
   logic [spv_pkg::NPINS-1:0] pin_meta;
   logic [spv_pkg::NPINS-1:0] pin_sync;
   logic                      oc_prev;
   logic [14:0]               pre_cnt;
   logic                      tick;
   logic [8:0]                ms_cnt;
   logic                      ms_clr;
   spv_pkg::spv_mode_type     st;
   spv_pkg::spv_mode_type     next_st;
   logic [3:0]                int_mask;
   logic [3:0]                io_status_register;
   logic                      can_fault;
   logic [1:0]                wd_sel;
   logic                      wd_win;
   logic                      lp_sleep;
   logic [7:0]                pulse_cnt;
   logic [3:0]                next_rdata;

   // Pin inputs pass two flip-flops; only the second stage is read.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
         oc_prev  <= 1'b0;
      end else begin
         pin_meta <= {battery_loss_flag, wake_event, overcurrent_wake,
                      main_regulator_output_low, battery_supply_low, tracker_undervoltage,
                      high_side_overheat, regulator_heat_warning, bus_fault_flag};
         pin_sync <= pin_meta;
         oc_prev  <= pin_sync[spv_pkg::P_OC];
      end
   end

   // Link decode; every access is answered one cycle after it is taken.
   wire acc     = link.req & ~link.ack;
   wire wr      = acc & link.we;
   wire rd      = acc & ~link.we;
   wire tim_wr  = wr & (link.addr == spv_pkg::DA_TIMING) & ~link.wdata[spv_pkg::TIM_SELECT];
   wire int_wr  = wr & (link.addr == spv_pkg::DA_INT);
   wire mode_wr = wr & (link.addr == spv_pkg::DA_MODE);
   wire ior_rd  = rd & (link.addr == spv_pkg::DA_IOR);
   wire can_rd  = rd & (link.addr == spv_pkg::DA_CAN);
   wire uv      = pin_sync[spv_pkg::P_UV];
   wire in_rst  = (st != spv_pkg::ST_NREQ) && (st != spv_pkg::ST_NORM);
   wire oc_edge = pin_sync[spv_pkg::P_OC] & ~oc_prev;

   // Watchdog period and its open-window check.
   wire [8:0] wd_per = spv_pkg::wd_period_ms(wd_sel);
   wire early = wd_win & (ms_cnt < (wd_per >> 1));
   wire [8:0] nreq_lim  = 9'(spv_pkg::NREQ_TIMEOUT_MS);
   wire [8:0] hold_lim  = 9'(spv_pkg::UV_SLEEP_HOLD_MS);
   wire [8:0] wdrst_lim = 9'(spv_pkg::WD_RESET_MS);
   wire [8:0] wake_lim  = 9'(spv_pkg::WAKE_RESET_MS);
   wire uv_sleep_ok = lp_sleep & ~pin_sync[spv_pkg::P_LOSS];
   wire spv_pkg::spv_mode_type uv_dest = uv_sleep_ok ? spv_pkg::ST_UVSLEEP
                                                     : spv_pkg::ST_UVSTOP;

   // Reported status and the interrupt cause, both gated by the mask.
   wire [3:0] int_stat = {io_status_register[spv_pkg::IOR_SUPPLY], io_status_register[spv_pkg::IOR_HSOT],
                          io_status_register[spv_pkg::IOR_HEAT], can_fault} & int_mask;
   wire trk_cause = io_status_register[spv_pkg::IOR_TRK] & int_mask[spv_pkg::INT_OT_TRK];
   wire int_low = (|int_stat) | trk_cause | (pulse_cnt != 8'h00)
                | (st == spv_pkg::ST_UVSTOP) | (st == spv_pkg::ST_UVSLEEP);

   // Millisecond prescaler shared by every timeout.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= '0;
         tick    <= 1'b0;
      end else begin
         tick    <= (pre_cnt == 15'(TICK_CYC - 1));
         pre_cnt <= (pre_cnt == 15'(TICK_CYC - 1)) ? '0 : pre_cnt + 15'h1;
      end
   end

   // Millisecond counter restarts on every mode change, refresh or low regulator in wake.
   assign ms_clr = (next_st != st) | tim_wr | ((st == spv_pkg::ST_WAKE) & uv);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt <= '0;
      end else if (ms_clr) begin
         ms_cnt <= '0;
      end else if (tick && ms_cnt != 9'h1ff) begin
         ms_cnt <= ms_cnt + 9'h1;
      end
   end

   // Mode sequencer next state.
   always_comb begin
      next_st = st;
      unique case (st)
         spv_pkg::ST_NREQ: begin
            if (uv) begin
               next_st = uv_dest;
            end else if (tim_wr) begin
               next_st = spv_pkg::ST_NORM;
            end else if (ms_cnt >= nreq_lim) begin
               next_st = spv_pkg::ST_WDRST;
            end
         end
         spv_pkg::ST_NORM: begin
            if (uv) begin
               next_st = uv_dest;
            end else if (tim_wr ? early : (ms_cnt >= wd_per)) begin
               next_st = spv_pkg::ST_WDRST;
            end
         end
         spv_pkg::ST_WDRST: begin
            if (ms_cnt >= wdrst_lim) begin
               next_st = spv_pkg::ST_NREQ;
            end
         end
         spv_pkg::ST_UVSTOP: begin
            if (!uv) begin
               next_st = spv_pkg::ST_NREQ;
            end
         end
         spv_pkg::ST_UVSLEEP: begin
            if (ms_cnt >= hold_lim) begin
               next_st = spv_pkg::ST_SLEEP;
            end
         end
         spv_pkg::ST_SLEEP: begin
            if (pin_sync[spv_pkg::P_WAKE]) begin
               next_st = spv_pkg::ST_WAKE;
            end
         end
         spv_pkg::ST_WAKE: begin
            if (!uv && ms_cnt >= wake_lim) begin
               next_st = spv_pkg::ST_NREQ;
            end
         end
         default: next_st = spv_pkg::ST_NREQ;
      endcase
   end

   // State and registered pins; reset comes up in normal-request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st                       <= spv_pkg::ST_NREQ;
         link.reset_n             <= 1'b1;
         link.timer_fault_n       <= 1'b0;
         link.int_n               <= 1'b1;
         main_regulator_output_en <= 1'b1;
         tracker_en               <= 1'b0;
         can_txrx_en              <= 1'b1;
      end else begin
         st                 <= next_st;
         link.reset_n       <= (next_st == spv_pkg::ST_NREQ) | (next_st == spv_pkg::ST_NORM);
         link.timer_fault_n <= (next_st != spv_pkg::ST_NREQ) & (next_st != spv_pkg::ST_WDRST);
         link.int_n         <= ~int_low;
         main_regulator_output_en <= next_st != spv_pkg::ST_SLEEP;
         tracker_en         <= next_st == spv_pkg::ST_NORM;
         can_txrx_en        <= (next_st == spv_pkg::ST_NREQ) | (next_st == spv_pkg::ST_NORM);
      end
   end
   assign mode = st;

   // Mask, timing and mode registers; mask and timing clear while reset is asserted.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_mask <= spv_pkg::INT_RESET;
         wd_sel   <= 2'h0;
         wd_win   <= 1'b0;
         lp_sleep <= 1'b0;
      end else if (in_rst) begin
         int_mask <= spv_pkg::INT_RESET;
         wd_sel   <= 2'h0;
         wd_win   <= 1'b0;
      end else begin
         if (int_wr) begin
            int_mask <= link.wdata;
         end
         if (tim_wr) begin
            wd_sel <= link.wdata[1:0];
            wd_win <= link.wdata[spv_pkg::TIM_WINDOW];
         end
         if (mode_wr) begin
            lp_sleep <= link.wdata[0];
         end
      end
   end

   // Latched fault flags; a fault present in the read cycle wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_status_register       <= '0;
         can_fault <= 1'b0;
      end else begin
         io_status_register[spv_pkg::IOR_HSOT]   <= (io_status_register[spv_pkg::IOR_HSOT] & ~ior_rd) | pin_sync[spv_pkg::P_HSOT];
         io_status_register[spv_pkg::IOR_TRK]    <= (io_status_register[spv_pkg::IOR_TRK] & ~ior_rd) | pin_sync[spv_pkg::P_TRK];
         io_status_register[spv_pkg::IOR_SUPPLY] <= (io_status_register[spv_pkg::IOR_SUPPLY] & ~ior_rd) | pin_sync[spv_pkg::P_SUP];
         io_status_register[spv_pkg::IOR_HEAT]   <= (io_status_register[spv_pkg::IOR_HEAT] & ~ior_rd) | pin_sync[spv_pkg::P_HEAT];
         can_fault <= (can_fault & ~can_rd) | pin_sync[spv_pkg::P_BUS];
      end
   end

   // Over-current wake with stop selected gives a pulse that no status bit records.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pulse_cnt <= '0;
      end else if (oc_edge && !lp_sleep && !in_rst) begin
         pulse_cnt <= 8'(spv_pkg::INT_PULSE_CYCLES);
      end else if (pulse_cnt != 8'h00) begin
         pulse_cnt <= pulse_cnt - 8'h1;
      end
   end

   // Read data selection; the timing register is write only.
   always_comb begin
      unique case (link.addr)
         spv_pkg::DA_INT:  next_rdata = int_stat;
         spv_pkg::DA_IOR:  next_rdata = io_status_register;
         spv_pkg::DA_CAN:  next_rdata = {3'h0, can_fault};
         spv_pkg::DA_MODE: next_rdata = {3'h0, lp_sleep};
         default:          next_rdata = 4'h0;
      endcase
   end

   // Answer strobe and read data.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.ack   <= 1'b0;
         link.rdata <= 4'h0;
      end else begin
         link.ack <= acc;
         if (rd) begin
            link.rdata <= next_rdata;
         end
      end
   end
endmodule : spv_device

// File: include/spv_pkg.sv
// Shared constants, register map and types for the supervisor and its host controller.
package spv_pkg;
   // Timebase: one millisecond tick derived from the 25 MHz clock.
   localparam int CLK_PERIOD_NS    = 40;
   localparam int TICK_US          = 1000;
   localparam int TICK_CYCLES      = TICK_US * 1000 / CLK_PERIOD_NS;
   localparam int INT_PULSE_US     = 10;
   localparam int INT_PULSE_CYCLES = INT_PULSE_US * 1000 / CLK_PERIOD_NS;
   // Sequencer times, counted in millisecond ticks.
   localparam int NREQ_TIMEOUT_MS  = 350;
   localparam int UV_SLEEP_HOLD_MS = 100;
   localparam int WD_RESET_MS      = 1;
   localparam int WAKE_RESET_MS    = 4;
   // Device register addresses on the link.
   localparam logic [2:0] DA_IOR    = 3'h2;
   localparam logic [2:0] DA_CAN    = 3'h3;
   localparam logic [2:0] DA_MODE   = 3'h4;
   localparam logic [2:0] DA_TIMING = 3'h5;
   localparam logic [2:0] DA_INT    = 3'h7;
   // Field positions of the interrupt register and the timing register.
   localparam int INT_SUPPLY = 3;
   localparam int INT_OT_TRK = 2;
   localparam int INT_HEAT   = 1;
   localparam int INT_BUS    = 0;
   localparam int TIM_SELECT = 3;
   localparam int TIM_WINDOW = 2;
   localparam logic [3:0] INT_RESET = 4'h0;
   // Latched IO status layout.
   localparam int IOR_HSOT   = 0;
   localparam int IOR_TRK    = 1;
   localparam int IOR_SUPPLY = 2;
   localparam int IOR_HEAT   = 3;
   // Positions of the synchronised device input pins.
   localparam int P_BUS  = 0;
   localparam int P_HEAT = 1;
   localparam int P_HSOT = 2;
   localparam int P_TRK  = 3;
   localparam int P_SUP  = 4;
   localparam int P_UV   = 5;
   localparam int P_OC   = 6;
   localparam int P_WAKE = 7;
   localparam int P_LOSS = 8;
   localparam int NPINS  = 9;
   // Host APB register offsets.
   localparam logic [11:0] HA_CMD      = 12'h000;
   localparam logic [11:0] HA_RDATA    = 12'h004;
   localparam logic [11:0] HA_STAT     = 12'h008;
   localparam logic [11:0] HA_IRQ_STAT = 12'h00c;
   localparam logic [11:0] HA_IRQ_MASK = 12'h010;
   localparam logic [11:0] HA_KICK     = 12'h014;
   localparam logic [11:0] HA_SNAP     = 12'h018;
   // Host interrupt status bits.
   localparam int HI_DEV_INT = 0;
   localparam int HI_DEV_RST = 1;
   localparam int HI_DONE    = 2;

   // Sequencer modes, Gray coded in the order listed.
   typedef enum logic [2:0] {
      ST_NREQ    = 3'h0,
      ST_NORM    = 3'h1,
      ST_WDRST   = 3'h3,
      ST_UVSTOP  = 3'h2,
      ST_UVSLEEP = 3'h6,
      ST_SLEEP   = 3'h7,
      ST_WAKE    = 3'h5
   } spv_mode_type;

   // Watchdog period in milliseconds for a period select code.
   function automatic logic [8:0] wd_period_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    wd_period_ms = 9'h00a;
         2'h1:    wd_period_ms = 9'h02d;
         2'h2:    wd_period_ms = 9'h064;
         default: wd_period_ms = 9'h15e;
      endcase
   endfunction : wd_period_ms
endpackage : spv_pkg

// File: include/spv_link_if.sv
// Register and pin link between the supervisor and its host controller.
`timescale 1ns/1ns
interface spv_link_if;
   logic       req;
   logic       we;
   logic [2:0] addr;
   logic [3:0] wdata;
   logic       ack;
   logic [3:0] rdata;
   logic       int_n;
   logic       reset_n;
   logic       timer_fault_n;

   modport dev (input req, we, addr, wdata, output ack, rdata, int_n, reset_n, timer_fault_n);
   modport host (output req, we, addr, wdata, input ack, rdata, int_n, reset_n, timer_fault_n);
endinterface : spv_link_if

// File: verilog/spv_host.sv
// Host controller: APB registers, watchdog refresh and interrupt service over the link.
`timescale 1ns/1ns
module spv_host #(
   parameter int TICK_CYC = spv_pkg::TICK_CYCLES
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   spv_link_if.host         link
);
   logic [7:0]  cmd;
   logic        cmd_pend;
   logic [3:0]  rd_last;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic [4:0]  kick_cfg;
   logic [11:0] snap;
   logic        ot_not_trk;
   logic        kick_pend;
   logic [1:0]  svc_step;
   logic [1:0]  org;
   logic        int_prev;
   logic        rst_prev;
   logic [14:0] pre_cnt;
   logic [8:0]  kcnt;

   // APB decode; every access completes in its first access cycle.
   wire apb_wr  = psel & penable & pwrite;
   wire apb_rd  = psel & penable & ~pwrite;
   wire hit     = (paddr == spv_pkg::HA_CMD) | (paddr == spv_pkg::HA_RDATA)
                | (paddr == spv_pkg::HA_STAT) | (paddr == spv_pkg::HA_IRQ_STAT)
                | (paddr == spv_pkg::HA_IRQ_MASK) | (paddr == spv_pkg::HA_KICK)
                | (paddr == spv_pkg::HA_SNAP);
   wire cmd_wr  = apb_wr & (paddr == spv_pkg::HA_CMD) & ~cmd_pend;
   wire w1c     = apb_wr & (paddr == spv_pkg::HA_IRQ_STAT);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // Link events seen by the host.
   wire done    = link.req & link.ack;
   wire int_fall = int_prev & ~link.int_n;
   wire rst_fall = rst_prev & ~link.reset_n;
   wire [2:0] ev = {done & (org == 2'h0), rst_fall, int_fall};
   wire [10:0] kick_x3 = 11'(spv_pkg::wd_period_ms(kick_cfg[2:1])) * 11'h3;
   wire [8:0]  kick_ms = 9'(kick_x3 >> 2);
   wire tick = (pre_cnt == 15'(TICK_CYC - 1));

   // Read data selection.
   always_comb begin
      unique case (paddr)
         spv_pkg::HA_CMD:      prdata = {23'h0, cmd_pend, cmd};
         spv_pkg::HA_RDATA:    prdata = {28'h0, rd_last};
         spv_pkg::HA_STAT:     prdata = {27'h0, ot_not_trk, link.timer_fault_n,
                                         link.reset_n, link.int_n, link.req};
         spv_pkg::HA_IRQ_STAT: prdata = {29'h0, irq_stat};
         spv_pkg::HA_IRQ_MASK: prdata = {29'h0, irq_mask};
         spv_pkg::HA_KICK:     prdata = {27'h0, kick_cfg};
         spv_pkg::HA_SNAP:     prdata = {20'h0, snap};
         default:              prdata = 32'h0;
      endcase
   end

   // Software registers and the sticky interrupt bits; a new event wins over a clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat <= '0;
         irq_mask <= '0;
         kick_cfg <= '0;
         int_prev <= 1'b1;
         rst_prev <= 1'b1;
         irq      <= 1'b0;
      end else begin
         irq_stat <= (irq_stat & ~(w1c ? pwdata[2:0] : 3'h0)) | ev;
         int_prev <= link.int_n;
         rst_prev <= link.reset_n;
         irq      <= |((irq_stat | ev) & irq_mask);
         if (apb_wr && paddr == spv_pkg::HA_IRQ_MASK) begin
            irq_mask <= pwdata[2:0];
         end
         if (apb_wr && paddr == spv_pkg::HA_KICK) begin
            kick_cfg <= pwdata[4:0];
         end
      end
   end

   // Refresh timer: a timing write well inside the period, also in normal-request.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt   <= '0;
         kcnt      <= '0;
         kick_pend <= 1'b0;
      end else begin
         pre_cnt <= tick ? '0 : pre_cnt + 15'h1;
         if (!link.reset_n || !kick_cfg[0]) begin
            kcnt <= '0;
         end else if (kcnt >= kick_ms) begin
            kcnt      <= '0;
            kick_pend <= 1'b1;
         end else if (tick) begin
            kcnt <= kcnt + 9'h1;
         end
         if (!link.req && !cmd_pend && kick_pend) begin
            kick_pend <= 1'b0;
         end
      end
   end

   // Link master: software command first, then refresh, then interrupt service reads.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.req   <= 1'b0;
         link.we    <= 1'b0;
         link.addr  <= 3'h0;
         link.wdata <= 4'h0;
         cmd        <= '0;
         cmd_pend   <= 1'b0;
         org        <= 2'h0;
         svc_step   <= 2'h0;
         rd_last    <= 4'h0;
         snap       <= '0;
         ot_not_trk <= 1'b0;
      end else begin
         if (cmd_wr) begin
            cmd      <= pwdata[7:0];
            cmd_pend <= 1'b1;
         end
         if (done) begin
            link.req <= 1'b0;
            if (org == 2'h0) begin
               rd_last <= link.rdata;
            end else if (org == 2'h2) begin
               snap     <= {snap[7:0], link.rdata};
               svc_step <= (svc_step == 2'h3) ? 2'h0 : svc_step + 2'h1;
               if (svc_step == 2'h1) begin
                  ot_not_trk <= link.rdata[spv_pkg::INT_OT_TRK];
               end
            end
         end else if (!link.req) begin
            if (cmd_pend) begin
               link.req   <= 1'b1;
               link.we    <= cmd[7];
               link.addr  <= cmd[6:4];
               link.wdata <= cmd[3:0];
               cmd_pend   <= 1'b0;
               org        <= 2'h0;
            end else if (kick_pend) begin
               link.req   <= 1'b1;
               link.we    <= 1'b1;
               link.addr  <= spv_pkg::DA_TIMING;
               link.wdata <= {1'b0, kick_cfg[3], kick_cfg[2:1]};
               org        <= 2'h1;
            end else if (kick_cfg[4] && (svc_step != 2'h0 || !link.int_n)) begin
               link.req   <= 1'b1;
               link.we    <= 1'b0;
               link.addr  <= (svc_step == 2'h0) ? spv_pkg::DA_INT
                           : (svc_step == 2'h2) ? spv_pkg::DA_IOR : spv_pkg::DA_CAN;
               link.wdata <= 4'h0;
               org        <= 2'h2;
               svc_step   <= (svc_step == 2'h0) ? 2'h1 : svc_step;
            end
         end
      end
   end
endmodule : spv_host

// File: sim/spv_link_checker.sv
// Assertion checker for the link between the supervisor and its host.
`timescale 1ns/1ns
module spv_link_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       req,
   input wire logic       we,
   input wire logic [2:0] addr,
   input wire logic [3:0] wdata,
   input wire logic       ack,
   input wire logic [3:0] rdata,
   input wire logic       int_n,
   input wire logic       reset_n,
   input wire logic       timer_fault_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // A timing register write completing on the link.
   wire tim_wr = ack && we && addr == spv_pkg::DA_TIMING && !wdata[spv_pkg::TIM_SELECT];
   // Handshake, read data and sequencer pin levels.
   a_ack_single: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (ack |-> $past(req))
      else $error("ack without request");
   a_ack_prompt: assert property (req && !ack |=> ack)
      else $error("ack late");
   a_req_release: assert property (ack |=> !req)
      else $error("request held after ack");
   a_req_steady: assert property (req && !ack |=> $stable({we, addr, wdata}))
      else $error("request changed while pending");
   a_rdata_hold: assert property ($changed(rdata) |-> ack && !we)
      else $error("read data changed outside a read");
   a_flag_release: assert property (tim_wr && reset_n && $past(reset_n) |-> timer_fault_n)
      else $error("fault pin not released");
   a_uv_flag_high: assert property (!reset_n && !int_n |-> timer_fault_n)
      else $error("fault pin low in undervoltage reset");
   // Main scenarios.
   c_tim_wr: cover property (tim_wr);
   c_int_low: cover property (!int_n && reset_n);
   c_uv_reset: cover property (!reset_n && !int_n);
endmodule : spv_link_checker

// File: sim/supervisor_irq_and_mode_sequencer_test.sv
// Self-checking test of the supervisor and its host controller.
`timescale 1ns/1ns
module supervisor_irq_and_mode_sequencer_test;
   localparam int TK = 25;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, irq, men, ten, cen, err;
   logic [3:0]  flt = 4'h0;
   logic        trk = 1'b0, mlow = 1'b0, ocw = 1'b0, wake = 1'b0, loss = 1'b0;
   spv_pkg::spv_mode_type mode;
   int          errors = 0, tests_run = 0, cyc = 0, n;
   spv_link_if  link ();
   spv_device #(.TICK_CYC(TK)) i_spv_device (.pclk(pclk), .presetn(presetn), .link(link),
      .bus_fault_flag(flt[0]), .regulator_heat_warning(flt[1]), .high_side_overheat(flt[2]),
      .tracker_undervoltage(trk), .battery_supply_low(flt[3]), .main_regulator_output_low(mlow),
      .overcurrent_wake(ocw), .wake_event(wake), .battery_loss_flag(loss),
      .main_regulator_output_en(men), .tracker_en(ten), .can_txrx_en(cen), .mode(mode));
   spv_host #(.TICK_CYC(TK)) i_spv_host (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
   spv_link_checker i_spv_link_checker (.pclk(pclk), .presetn(presetn), .req(link.req),
      .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
      .int_n(link.int_n), .reset_n(link.reset_n), .timer_fault_n(link.timer_fault_n));
   // Clock of 40 ns.
   initial begin
      forever #20 pclk = ~pclk;
   end
   // Cycle count; a hang ends the run as a failure.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int k);
      repeat (k) @(posedge pclk);
   endtask : idle
   // One APB transfer; read data and error are taken at the pready edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Device register access through the host command register.
   task automatic dev(input logic w, input logic [2:0] a, input logic [3:0] d);
      apb(1'b1, spv_pkg::HA_CMD, {24'h0, w, a, d});
      do apb(1'b0, spv_pkg::HA_CMD, 32'h0); while (rd[8] !== 1'b0);
      apb(1'b0, spv_pkg::HA_RDATA, 32'h0);
   endtask : dev
   task automatic wait_mode(input spv_pkg::spv_mode_type m);
      n = 0;
      while (mode !== m) begin
         @(negedge pclk);
         n++;
      end
   endtask : wait_mode
   // Main sequence.
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      idle(1);
      chk({men, ten, cen, link.timer_fault_n, mode}, {4'b1010, spv_pkg::ST_NREQ});
      dev(1'b0, spv_pkg::DA_INT, 4'h0);
      chk(rd, 32'h0);
      apb(1'b0, 12'h01c, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      wait_mode(spv_pkg::ST_WDRST);
      chk(cyc > 349 * TK && cyc < 352 * TK, 1'b1);
      chk(link.timer_fault_n, 1'b0);
      wait_mode(spv_pkg::ST_NREQ);
      chk({irq, link.reset_n}, 2'b01);
      apb(1'b1, spv_pkg::HA_IRQ_MASK, 32'h2);
      idle(2);
      chk(irq, 1'b1);
      apb(1'b1, spv_pkg::HA_IRQ_STAT, 32'h2);
      idle(2);
      chk(irq, 1'b0);
      dev(1'b1, spv_pkg::DA_TIMING, 4'h0);
      chk({mode, ten, link.timer_fault_n}, {spv_pkg::ST_NORM, 2'b11});
      wait_mode(spv_pkg::ST_WDRST);
      chk(n > 8 * TK && n < 11 * TK, 1'b1);
      wait_mode(spv_pkg::ST_NREQ);
      dev(1'b1, spv_pkg::DA_TIMING, 4'h3);
      apb(1'b1, spv_pkg::HA_KICK, 32'h7);
      for (int i = 0; i < 4; i++) begin
         dev(1'b1, spv_pkg::DA_INT, 4'h1 << i);
         flt[i] <= 1'b1;
         idle(6);
         flt[i] <= 1'b0;
         idle(6);
         chk(link.int_n, 1'b0);
         dev(1'b0, spv_pkg::DA_INT, 4'h0);
         chk(rd, 32'h1 << i);
         dev(1'b0, (i == 0) ? spv_pkg::DA_CAN : spv_pkg::DA_IOR, 4'h0);
         chk(link.int_n, 1'b1);
      end
      dev(1'b1, spv_pkg::DA_INT, 4'h4);
      trk <= 1'b1;
      flt[0] <= 1'b1;
      idle(6);
      trk <= 1'b0;
      flt[0] <= 1'b0;
      dev(1'b0, spv_pkg::DA_INT, 4'h0);
      chk({rd[30:0], link.int_n}, 32'h0);
      dev(1'b0, spv_pkg::DA_IOR, 4'h0);
      chk({rd[30:0], link.int_n}, 32'h5);
      dev(1'b0, spv_pkg::DA_CAN, 4'h0);
      chk(rd, 32'h1);
      apb(1'b1, spv_pkg::HA_KICK, 32'h17);
      flt[2] <= 1'b1;
      idle(6);
      flt[2] <= 1'b0;
      idle(40);
      apb(1'b0, spv_pkg::HA_STAT, 32'h0);
      chk(rd, 32'h1e);
      apb(1'b0, spv_pkg::HA_SNAP, 32'h0);
      chk(rd, 32'h410);
      apb(1'b1, spv_pkg::HA_KICK, 32'h7);
      ocw <= 1'b1;
      idle(6);
      ocw <= 1'b0;
      chk(link.int_n, 1'b0);
      dev(1'b0, spv_pkg::DA_INT, 4'h0);
      chk(rd, 32'h0);
      idle(260);
      mlow <= 1'b1;
      idle(6);
      chk({mode, link.reset_n, link.int_n}, {spv_pkg::ST_UVSTOP, 2'b00});
      mlow <= 1'b0;
      wait_mode(spv_pkg::ST_NREQ);
      chk(link.reset_n, 1'b1);
      dev(1'b1, spv_pkg::DA_MODE, 4'h1);
      mlow <= 1'b1;
      wait_mode(spv_pkg::ST_UVSLEEP);
      wait_mode(spv_pkg::ST_SLEEP);
      chk(n > 98 * TK && n < 102 * TK, 1'b1);
      chk({men, ten, link.reset_n}, 3'b000);
      wake <= 1'b1;
      mlow <= 1'b0;
      wait_mode(spv_pkg::ST_WAKE);
      wake <= 1'b0;
      chk(link.reset_n, 1'b0);
      wait_mode(spv_pkg::ST_NREQ);
      chk({n > 3 * TK, link.reset_n, men}, 3'b111);
      end_of_test();
   end
endmodule : supervisor_irq_and_mode_sequencer_test
